/* File: src/sdb_mem.sv */
/*
 * memory end: bank/row state, burst address generation, mode register,
 * byte-lane masking and self-timed auto precharge.
 * assumes the controller keeps the power-up order and legal timing.
 */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sdb_mem #(
    parameter int DW = 16,
    parameter int DEPTH_W = 10,
    parameter int CL = 2
) (
    input wire logic clk,
    input wire logic reset,
    sdb_if.mem link,
    input wire logic power_down,
    output logic [sdb_pkg::NBANKS-1:0] bank_open,
    output logic [11:0] mode_word
);
    localparam int NB = sdb_pkg::NBANKS;
    localparam int CW = sdb_pkg::COL_W;

    logic [DW-1:0] mem [0:(1<<DEPTH_W)-1];
    logic [NB-1:0] open_q, open_d;
    logic [sdb_pkg::ROW_W-1:0] row_q [NB], row_d [NB];
    logic [11:0] mode_q, mode_d;
    logic rd_q, rd_d, wr_q, wr_d, ap_q, ap_d;
    logic [sdb_pkg::BANK_W-1:0] bb_q, bb_d;
    logic [CW-1:0] start_q, start_d, cnt_q, cnt_d, len_q, len_d;
    logic [CL-1:0][DW-1:0] pipe_q;
    logic [CL-1:0] pv_q;
    logic [1:0] mask_rd_q;
    logic [NB-1:0][1:0] apt_q, apt_d;
    logic [DW-1:0] dout_q;
    logic dv_q;
    logic [DW-1:0] wdat_q;
    logic [DW/8-1:0] wmask_q;

    // burst length in columns from mode field
    function automatic logic [CW-1:0] blen(input logic [2:0] f);
        unique case (f)
            sdb_pkg::BL_1: blen = 10'h001;
            sdb_pkg::BL_2: blen = 10'h002;
            sdb_pkg::BL_4: blen = 10'h004;
            sdb_pkg::BL_8: blen = 10'h008;
            default: blen = 10'h000; // page: wraps mod 1024
        endcase
    endfunction

    // column of access n within the block
    function automatic logic [CW-1:0] colgen(input logic [CW-1:0] st,
            input logic [CW-1:0] n, input logic [CW-1:0] len,
            input logic il);
        logic [CW-1:0] m;
        m = len - 10'h001; // block offset mask; page gives all ones
        if (il && len != 10'h000)
            colgen = (st & ~m) | ((st ^ n) & m);
        else
            colgen = (st & ~m) | ((st + n) & m);
    endfunction

    logic [3:0] c;
    logic [CW-1:0] col;
    logic il;
    assign c = link.cmd;
    assign il = mode_q[sdb_pkg::MR_BT_BIT] && len_q != 10'h001;
    assign col = colgen(start_q, cnt_q, len_q, il);

    // command decode and burst state
    always_comb begin
        open_d = open_q;
        row_d = row_q;
        mode_d = mode_q;
        rd_d = rd_q;
        wr_d = wr_q;
        ap_d = ap_q;
        bb_d = bb_q;
        start_d = start_q;
        len_d = len_q;
        apt_d = apt_q;
        cnt_d = cnt_q + 10'h001;
        for (int b = 0; b < NB; b++) begin
            if (apt_q[b] != 2'h0) begin
                apt_d[b] = apt_q[b] - 2'h1;
                if (apt_q[b] == 2'h1)
                    open_d[b] = 1'b0;
            end
        end
        if ((rd_q || wr_q) && len_q != 10'h000 && cnt_q + 10'h001 == len_q)
            begin
            rd_d = 1'b0;
            wr_d = 1'b0;
            if (ap_q)
                apt_d[bb_q] = 2'(sdb_pkg::T_AP_CYC);
        end
        if (!c[3] && !power_down) begin
            unique case (c)
                sdb_pkg::CMD_ACT: begin
                    open_d[link.bank] = 1'b1;
                    row_d[link.bank] = link.addr;
                end
                sdb_pkg::CMD_RD, sdb_pkg::CMD_WR: begin
                    rd_d = (c == sdb_pkg::CMD_RD);
                    wr_d = (c == sdb_pkg::CMD_WR);
                    bb_d = link.bank;
                    start_d = link.addr[CW-1:0];
                    ap_d = link.addr[sdb_pkg::AP_BIT];
                    len_d = blen(mode_q[sdb_pkg::MR_BL_LSB +: 3]);
                    cnt_d = 10'h000;
                end
                sdb_pkg::CMD_BST: begin
                    rd_d = 1'b0;
                    wr_d = 1'b0;
                end
                sdb_pkg::CMD_PRE: begin
                    if (link.addr[sdb_pkg::AP_BIT])
                        open_d = '0;
                    else
                        open_d[link.bank] = 1'b0;
                end
                sdb_pkg::CMD_MRS: mode_d = link.addr;
                default: ; // nop and refresh change no state
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            open_q <= '0;
            mode_q <= sdb_pkg::MODE_RESET;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
            bb_q <= '0;
            start_q <= '0;
            cnt_q <= '0;
            len_q <= '0;
            apt_q <= '0;
            for (int b = 0; b < NB; b++)
                row_q[b] <= '0;
        end else begin
            open_q <= open_d;
            mode_q <= mode_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            ap_q <= ap_d;
            bb_q <= bb_d;
            start_q <= start_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            apt_q <= apt_d;
            row_q <= row_d;
        end
    end

    // array address truncates {bank, row, column} to the model depth, so with DEPTH_W 10 only the column remains
    logic [DEPTH_W-1:0] aa;
    assign aa = DEPTH_W'({bb_q, row_q[bb_q], col});

    // storage: each beat and its lane mask are taken off the wire
    // together, then written once the burst counter names their column
    always_ff @(posedge clk) begin
        wdat_q <= link.dq_i;
        wmask_q <= link.byte_lane_mask;
        if (wr_q) begin
            for (int l = 0; l < DW/8; l++)
                if (!wmask_q[l])
                    mem[aa][l*8 +: 8] <= wdat_q[l*8 +: 8];
        end
    end

    // read latency pipe and two-cycle output mask
    always_ff @(posedge clk) begin
        if (reset) begin
            pipe_q <= '0;
            pv_q <= '0;
            mask_rd_q <= '0;
            dout_q <= '0;
            dv_q <= 1'b0;
        end else begin
            pipe_q <= {pipe_q[CL-2:0], mem[aa]};
            pv_q <= {pv_q[CL-2:0], rd_q};
            mask_rd_q <= {mask_rd_q[0], link.byte_lane_mask[0]};
            dout_q <= pipe_q[CL-1];
            dv_q <= pv_q[CL-1] && !mask_rd_q[1];
        end
    end

    assign link.dq_mem_o = dout_q;
    assign link.dq_mem_oe = dv_q;
    assign bank_open = open_q;
    assign mode_word = mode_q;
endmodule

/* File: src/sdb_pkg.sv */
/*
 * shared constants for the sdram burst link: command codes, address
 * layout, mode register fields and power-up timing.
 * assumes a single 50 MHz clock shared by both ends.
 */
package sdb_pkg;
    localparam int ROW_W = 12;
    localparam int COL_W = 10;
    localparam int BANK_W = 2;
    localparam int NBANKS = 4;
    localparam int AP_BIT = 10;
    // command code {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_INH = 4'h8;
    // mode register fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [11:0] MODE_RESET = 12'h000;
    // power-up wait and auto-precharge timing
    localparam int CLK_MHZ = 50;
    localparam int T_INIT_US = 100;
    localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
    localparam int AUTO_REFRESHES = 2;
    localparam int T_PRE_CYC = 3;
    localparam int T_REF_CYC = 4;
    localparam int T_AP_CYC = 2;
endpackage

/* File: src/sdb_if.sv */
/*
 * command and data link between controller and memory.
 * the bench resolves the shared data wire from the two enables.
 */
`timescale 1ns/1ps
interface sdb_if #(parameter int DW = 16);
    logic [3:0] cmd;
    logic [sdb_pkg::BANK_W-1:0] bank;
    logic [sdb_pkg::ROW_W-1:0] addr;
    logic [DW/8-1:0] byte_lane_mask;
    logic [DW-1:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [DW-1:0] dq_mem_o;
    logic dq_mem_oe;
    logic [DW-1:0] dq_i;
    modport ctl (output cmd, output bank, output addr,
        output byte_lane_mask, output dq_ctl_o, output dq_ctl_oe,
        input dq_mem_oe, input dq_i);
    modport mem (input cmd, input bank, input addr, input byte_lane_mask,
        output dq_mem_o, output dq_mem_oe, input dq_i);
endinterface

/* File: src/sdb_ctl.sv */
/*
 * controller end: power-up sequence, then single-beat user orders
 * turned into link commands.
 * assumes the memory answers reads after its programmed latency.
 */
`timescale 1ns/1ps
module sdb_ctl #(
    parameter int DW = 16,
    parameter int INIT_CYC = sdb_pkg::INIT_CYC,
    parameter logic [11:0] MODE_WORD = 12'h003
) (
    input wire logic clk,
    input wire logic reset,
    sdb_if.ctl link,
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic [1:0] req_bank,
    input wire logic [11:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    input wire logic [DW/8-1:0] req_mask,
    output logic req_ready,
    output logic init_done,
    output logic [DW-1:0] rdata,
    output logic rdata_valid
);
    typedef enum logic [2:0] {
        S_WAIT, S_PRE, S_REF, S_MRS, S_RUN
    } sdb_st_t;
    sdb_st_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [1:0] nref_q, nref_d;
    logic [3:0] cmd_q, cmd_d;
    logic [1:0] bank_q, bank_d;
    logic [11:0] addr_q, addr_d;
    logic [DW-1:0] wd_q, wd_d;
    logic [DW/8-1:0] mk_q, mk_d;
    logic oe_q, oe_d;

    // power-up sequence, then pass user orders
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q == 0) ? cnt_q : cnt_q - 32'h1;
        nref_d = nref_q;
        cmd_d = sdb_pkg::CMD_NOP;
        bank_d = bank_q;
        addr_d = addr_q;
        wd_d = wd_q;
        mk_d = '0;
        oe_d = 1'b0;
        unique case (st_q)
            S_WAIT: if (cnt_q == 0) begin
                cmd_d = sdb_pkg::CMD_PRE;
                addr_d = 12'h001 << sdb_pkg::AP_BIT; // all banks
                st_d = S_PRE;
                cnt_d = 32'(sdb_pkg::T_PRE_CYC);
            end
            S_PRE: if (cnt_q == 0) begin
                cmd_d = sdb_pkg::CMD_REF;
                nref_d = nref_q + 2'h1;
                cnt_d = 32'(sdb_pkg::T_REF_CYC);
                if (nref_q + 2'h1 == 2'(sdb_pkg::AUTO_REFRESHES))
                    st_d = S_REF;
            end
            S_REF: if (cnt_q == 0) begin
                cmd_d = sdb_pkg::CMD_MRS;
                addr_d = MODE_WORD;
                st_d = S_MRS;
                cnt_d = 32'(sdb_pkg::T_PRE_CYC);
            end
            S_MRS: if (cnt_q == 0)
                st_d = S_RUN;
            S_RUN: if (req_valid) begin // user ordered
                cmd_d = req_cmd;
                bank_d = req_bank;
                addr_d = req_addr;
                wd_d = req_wdata;
                mk_d = req_mask;
                oe_d = (req_cmd == sdb_pkg::CMD_WR);
            end
        endcase
    end

    // sequence registers
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= S_WAIT;
            cnt_q <= 32'(INIT_CYC);
            nref_q <= '0;
            cmd_q <= sdb_pkg::CMD_NOP;
            bank_q <= '0;
            addr_q <= '0;
            wd_q <= '0;
            mk_q <= '0;
            oe_q <= 1'b0;
            rdata <= '0;
            rdata_valid <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            nref_q <= nref_d;
            cmd_q <= cmd_d;
            bank_q <= bank_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            mk_q <= mk_d;
            oe_q <= oe_d;
            rdata <= link.dq_i;
            // read data valid follows the memory's drive enable
            rdata_valid <= link.dq_mem_oe;
        end
    end

    assign link.cmd = cmd_q;
    assign link.bank = bank_q;
    assign link.addr = addr_q;
    assign link.byte_lane_mask = mk_q;
    assign link.dq_ctl_o = wd_q;
    assign link.dq_ctl_oe = oe_q;
    assign req_ready = (st_q == S_RUN);
    assign init_done = (st_q == S_RUN);
endmodule

/* File: test/sdb_properties.sv */
/*
 * checker for the controller-to-memory link: power-up order, command
 * order and data wire ownership.
 * assumes it is instantiated beside the link with the same init count.
 */
`timescale 1ns/1ps
module sdb_properties #(
    parameter int INIT_CYC = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] cmd,
    input wire logic [1:0] bank,
    input wire logic [11:0] addr,
    input wire logic dq_ctl_oe,
    input wire logic dq_mem_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] cyc_q, cyc_d;
    logic [2:0] ncmd_q, ncmd_d;
    logic [3:0] open_q, open_d;
    logic [4:0] rd_q, rd_d;
    logic quiet;
    logic col_cmd;
    // nop or deselect counts as quiet
    assign quiet = cmd[3] || cmd == sdb_pkg::CMD_NOP;
    assign col_cmd = cmd == sdb_pkg::CMD_RD || cmd == sdb_pkg::CMD_WR;
    // cycle count, command count, open banks, recent reads
    always_comb begin
        cyc_d = (cyc_q == 16'hffff) ? cyc_q : cyc_q + 16'h1;
        ncmd_d = (!quiet && ncmd_q != 3'h7) ? ncmd_q + 3'h1 : ncmd_q;
        rd_d = {rd_q[3:0], cmd == sdb_pkg::CMD_RD};
        open_d = open_q;
        if (cmd == sdb_pkg::CMD_ACT) begin
            open_d[bank] = 1'b1;
        end
        if (cmd == sdb_pkg::CMD_PRE) begin
            open_d = addr[10] ? 4'h0 : open_q & ~(4'h1 << bank);
        end
        if (col_cmd && addr[10]) begin
            open_d[bank] = 1'b0;
        end
    end
    // registers for the helper state
    always_ff @(posedge clk) begin
        if (reset) begin
            cyc_q <= 16'h0;
            ncmd_q <= 3'h0;
            open_q <= 4'h0;
            rd_q <= 5'h0;
        end else begin
            cyc_q <= cyc_d;
            ncmd_q <= ncmd_d;
            open_q <= open_d;
            rd_q <= rd_d;
        end
    end
    init_quiet_a: assert property ((cyc_q < INIT_CYC) |-> quiet)
        else $error("command during power-up wait");
    init_pre_a: assert property ((!quiet && ncmd_q == 3'h0) |->
        cmd == sdb_pkg::CMD_PRE && addr[10]) else $error("no precharge all");
    two_ref_a: assert property ((!quiet && ncmd_q inside {3'h1, 3'h2}) |->
        cmd == sdb_pkg::CMD_REF) else $error("refresh missing");
    mode_first_a: assert property ((!quiet && ncmd_q == 3'h3) |->
        cmd == sdb_pkg::CMD_MRS) else $error("mode load missing");
    mode_legal_a: assert property (cmd == sdb_pkg::CMD_MRS |->
        addr[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7})
        else $error("reserved burst length");
    act_first_a: assert property (col_cmd |-> open_q[bank])
        else $error("access to closed bank");
    write_data_a: assert property (cmd == sdb_pkg::CMD_WR |->
        dq_ctl_oe && !dq_mem_oe) else $error("write data not driven");
    read_answer_a: assert property ($rose(dq_mem_oe) |-> rd_q != 5'h0)
        else $error("memory drove without a read");
endmodule

/* File: test/tb.sv */
/*
 * bench: controller and memory joined by the link; random accesses.
 * assumes a 50 MHz clock and a shortened power-up wait.
 */
`timescale 1ns/1ps
module tb;
    localparam int IC = 20;
    logic clk = 0, reset = 1, power_down = 0, req_valid = 0;
    logic [3:0] req_cmd = 4'h7;
    logic [1:0] req_bank = 2'h0, req_mask = 2'h0;
    logic [11:0] req_addr = 12'h0;
    logic [15:0] req_wdata = 16'h0, dq_last = 16'h0, d, e, x;
    logic [9:0] c;
    logic req_ready, init_done, rdata_valid;
    logic [15:0] rdata;
    logic [3:0] bank_open;
    logic [11:0] mode_word;
    int failures = 0, n_tests = 0, i, n;
    sdb_if #(.DW(16)) link ();
    // released data wire shows a pattern that changes every cycle
    assign link.dq_i = link.dq_ctl_oe ? link.dq_ctl_o :
        link.dq_mem_oe ? link.dq_mem_o : ~dq_last;
    always @(posedge clk) dq_last <= link.dq_i;
    sdb_ctl #(.DW(16), .INIT_CYC(IC), .MODE_WORD(12'h008)) sdb_ctl_inst (
        .clk(clk), .reset(reset), .link(link.ctl), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_mask(req_mask), .req_ready(req_ready),
        .init_done(init_done), .rdata(rdata), .rdata_valid(rdata_valid));
    sdb_mem #(.DW(16)) sdb_mem_inst (.clk(clk), .reset(reset),
        .link(link.mem), .power_down(power_down), .bank_open(bank_open),
        .mode_word(mode_word));
    sdb_properties #(.INIT_CYC(IC)) sdb_properties_inst (.clk(clk),
        .reset(reset), .cmd(link.cmd), .bank(link.bank), .addr(link.addr),
        .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] s, x);
        n_tests++;
        if (s !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one order held until the controller takes it
    task automatic req(input logic [3:0] k, input logic [1:0] b,
            input logic [11:0] a, input logic [15:0] w, input logic [1:0] m);
        req_valid <= 1'b1;
        req_cmd <= k;
        req_bank <= b;
        req_addr <= a;
        req_wdata <= w;
        req_mask <= m;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        if (i == 50) begin
            failures++;
            close_out();
        end
        @(posedge clk); // one idle edge before the next order
    endtask
    // read one column and compare the beat the controller hands back
    task automatic rd(input logic [1:0] b, input logic [11:0] a);
        req(sdb_pkg::CMD_RD, b, a, 16'h0, 2'h0);
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            if (rdata_valid === 1'b1) break;
        end
        chk("read data", rdata, x);
        if (i == 12) begin
            failures++;
            close_out();
        end
    endtask
    // count the beats of one read answer and keep the first
    task automatic beats(output int k, output logic [15:0] f);
        k = 0;
        f = 16'h0;
        for (i = 0; i < 16 && (k == 0 || rdata_valid === 1'b1); i++) begin
            @(posedge clk);
            if (rdata_valid === 1'b1 && k == 0) f = rdata;
            if (rdata_valid === 1'b1) k++;
        end
        if (i == 16) begin
            failures++;
            close_out();
        end
    endtask
    task automatic wait_open(input logic [3:0] v);
        for (i = 0; i < 16 && bank_open !== v; i++) @(posedge clk);
        chk("bank_open", bank_open, v);
    endtask
    initial begin
        void'($urandom(16));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 400 && init_done !== 1'b1; i++) @(posedge clk);
        chk("init_done", init_done, 1'b1);
        if (init_done !== 1'b1) close_out();
        chk("mode_word", mode_word, 12'h008);
        for (int b = 0; b < 4; b++) begin
            c = (b == 0) ? 10'h3ff : 10'($urandom);
            d = 16'($urandom);
            e = 16'($urandom);
            x = d;
            req(sdb_pkg::CMD_ACT, 2'(b), 12'($urandom), 16'h0, 2'h0);
            if (b > 0) req(sdb_pkg::CMD_PRE, 2'(b - 1), 12'h0, 16'h0, 2'h0);
            wait_open(4'h1 << b);
            req(sdb_pkg::CMD_WR, 2'(b), {2'h0, c}, d, 2'h0);
            rd(2'(b), {2'h0, c});
            x = {e[15:8], d[7:0]};
            req(sdb_pkg::CMD_WR, 2'(b), {2'h0, c}, e, 2'h1);
            rd(2'(b), {2'h0, c});
            power_down <= 1'b1;
            req(sdb_pkg::CMD_WR, 2'(b), {2'h0, c}, ~e, 2'h0);
            for (i = 0; i < 8 && link.cmd !== sdb_pkg::CMD_WR; i++)
                @(posedge clk);
            if (i == 8) begin
                failures++;
                close_out();
            end
            @(posedge clk);
            power_down <= 1'b0;
            rd(2'(b), {2'h0, c});
            $display("test %0d done", b);
        end
        rd(2'h3, {2'h1, c});
        wait_open(4'h0);
        // burst of four, then a read cut short by a terminate
        req(sdb_pkg::CMD_MRS, 2'h0, 12'h002, 16'h0, 2'h0);
        req(sdb_pkg::CMD_ACT, 2'h1, 12'($urandom), 16'h0, 2'h0);
        wait_open(4'h2);
        chk("mode_word", mode_word, 12'h002);
        req(sdb_pkg::CMD_WR, 2'h1, {2'h0, c}, d, 2'h0);
        req(sdb_pkg::CMD_RD, 2'h1, {2'h0, c}, 16'h0, 2'h0);
        beats(n, e);
        chk("burst beats", 16'(n), 16'h0004);
        chk("burst data", e, d);
        req(sdb_pkg::CMD_RD, 2'h1, {2'h0, c}, 16'h0, 2'h0);
        // terminate two cycles after the read leaves two beats
        req(sdb_pkg::CMD_BST, 2'h0, 12'h0, 16'h0, 2'h0);
        beats(n, e);
        chk("cut beats", 16'(n), 16'h0002);
        chk("cut data", e, d);
        $display("test burst done");
        close_out();
    end
endmodule
